// *** verilog/fsled_pkg.sv ***
/*
 Package for the fieldbus state and error LED indicator: state codes,
 pattern selections and timing constants.
 Assumes a 25 MHz system clock.
*/
package fsled_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ        = 25000000;
	localparam int unsigned TICK_MS       = 1;
	localparam int unsigned TICK_CYC      = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned BLINK_MS      = 200;   // 2.5 Hz half period
	localparam int unsigned FLICK_MS      = 50;    // 10 Hz half period
	localparam int unsigned LONG_OFF_MS   = 1000;  // Pause after flashes
	localparam int unsigned ACT_MS        = 50;    // Link activity flicker half period
	localparam logic [7:0]  CHANGE_ERR    = 8'h01; // Status change flag value for error

	// ------------------------------------------------------------
	// Slave communication states
	// ------------------------------------------------------------
	typedef enum logic [2:0]
	{
		FSLED_ST_BOOT   = 3'h0,
		FSLED_ST_INIT   = 3'h1,
		FSLED_ST_PREOP  = 3'h2,
		FSLED_ST_BOOTST = 3'h3,
		FSLED_ST_SAFEOP = 3'h4,
		FSLED_ST_OP     = 3'h5
	} fsled_state_t;

	// Pattern selection, one-hot
	typedef enum logic [6:0]
	{
		PAT_OFF    = 7'h01,
		PAT_ON     = 7'h02,
		PAT_BLINK  = 7'h04,
		PAT_FLICK  = 7'h08,
		PAT_SINGLE = 7'h10,
		PAT_DOUBLE = 7'h20,
		PAT_SPARE  = 7'h40
	} fsled_pat_t;

	// Error inputs from the slave controller
	typedef struct packed
	{
		logic       pdi_wdog;   // Process data interface watchdog expired
		logic       cfg_err;    // General configuration error
		logic       app_wdog;   // Application watchdog expired
		logic [7:0] change;     // Status change flag
	} fsled_err_t;

endpackage

// *** verilog/fsled_indicator.sv ***
/*
 Fieldbus state / error LED pattern generator with two link/activity LEDs.
 Assumes state and error inputs come from logic on mclk_i; link inputs are
 pins and are synchronised here. LEDs are active high.
*/
`timescale 1ns/1ps

// Summary of operation
// - Status LED steady on while state is operational.
// - Pre-operational blinks status LED 200 ms on, 200 ms off.
// - Safe-operational gives single flash: 200 ms on, 1000 ms off.
// - Booting, bootstrap or firmware download flickers status LED 50/50 ms.
// - Status LED dark in init state.
// - Process data watchdog timeout lights error LED steadily.
// - Configuration error blinks error LED 200 ms on, 200 ms off.
// - Init reached with change flag 0x01 flickers error LED 50/50 ms.
// - Autonomous state change with flag 0x01 gives single red flash.
// - Application watchdog timeout gives red double flash then 1000 ms off.
// - Link LED on for idle link, flickers with traffic, off when invalid.
module fsled_indicator
	import fsled_pkg::*;
(
	input  wire logic         mclk_i,
	input  wire logic         rstn_i,
	input  wire fsled_state_t state_i,
	input  wire logic         fw_download_i,
	input  wire fsled_err_t   err_i,
	input  wire logic [1:0]   link_valid_i,
	input  wire logic [1:0]   link_traffic_i,
	output logic              status_led_o,
	output logic              error_led_o,
	output logic              link_activity_in_indicator_o,
	output logic              link_activity_out_indicator_o
);

	// ------------------------------------------------------------
	// Millisecond tick
	// ------------------------------------------------------------
	logic [14:0] pre_r;
	logic        tick_ms;

	assign tick_ms = (pre_r == 15'(TICK_CYC - 1));

	// Prescaler from the system clock
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			pre_r <= 15'h0000;
		else
			pre_r <= tick_ms ? 15'h0000 : pre_r + 15'h0001;
	end

	// ------------------------------------------------------------
	// Pattern phase decoding, shared by both LEDs
	// ------------------------------------------------------------
	// Level of a pattern at millisecond position ms within its period
	function automatic logic pat_level(input fsled_pat_t p, input logic [10:0] ms);
		logic lvl;
		lvl = 1'b0;
		case (p)
			PAT_ON:     lvl = 1'b1;
			PAT_BLINK:  lvl = (ms < 11'(BLINK_MS));
			PAT_FLICK:  lvl = (ms < 11'(FLICK_MS));
			PAT_SINGLE: lvl = (ms < 11'(BLINK_MS));
			PAT_DOUBLE: lvl = (ms < 11'(BLINK_MS))
					|| (ms >= 11'(2 * BLINK_MS) && ms < 11'(3 * BLINK_MS));
			default:    lvl = 1'b0;
		endcase
		return lvl;
	endfunction

	// Period length minus one, in ms
	function automatic logic [10:0] pat_last(input fsled_pat_t p);
		logic [10:0] n;
		n = 11'h000;
		case (p)
			PAT_BLINK:  n = 11'(2 * BLINK_MS - 1);
			PAT_FLICK:  n = 11'(2 * FLICK_MS - 1);
			PAT_SINGLE: n = 11'(BLINK_MS + LONG_OFF_MS - 1);
			PAT_DOUBLE: n = 11'(3 * BLINK_MS + LONG_OFF_MS - 1);
			default:    n = 11'h000;
		endcase
		return n;
	endfunction

	// ------------------------------------------------------------
	// Pattern selection
	// ------------------------------------------------------------
	fsled_pat_t grn_sel;
	fsled_pat_t red_sel;
	logic       chg_err;

	assign chg_err = (err_i.change == CHANGE_ERR);

	// Green from communication state; download overrides the state
	assign grn_sel = fw_download_i                 ? PAT_FLICK  :
			 (state_i == FSLED_ST_OP)      ? PAT_ON     :
			 (state_i == FSLED_ST_PREOP)   ? PAT_BLINK  :
			 (state_i == FSLED_ST_SAFEOP)  ? PAT_SINGLE :
			 (state_i == FSLED_ST_INIT)    ? PAT_OFF    :
			 PAT_FLICK;

	// Red by fixed priority; steady-on wins so a dead controller is never hidden
	assign red_sel = err_i.pdi_wdog                          ? PAT_ON     :
			 err_i.cfg_err                           ? PAT_BLINK  :
			 (chg_err && state_i == FSLED_ST_INIT)   ? PAT_FLICK  :
			 chg_err                                 ? PAT_SINGLE :
			 err_i.app_wdog                          ? PAT_DOUBLE :
			 PAT_OFF;

	// ------------------------------------------------------------
	// Phase counters, one per colour
	// ------------------------------------------------------------
	fsled_pat_t  cur_r   [2];
	logic [10:0] ms_r    [2];
	fsled_pat_t  sel     [2];
	logic [1:0]  led_nxt;
	logic [1:0]  led_r;

	assign sel[0] = grn_sel;
	assign sel[1] = red_sel;

	generate
		for (genvar g = 0; g < 2; g++)
		begin : g_col
			// Restart at zero on a new selection, else wrap at the period end
			always_ff @(posedge mclk_i or negedge rstn_i)
			begin
				if (!rstn_i)
				begin
					cur_r[g] <= PAT_OFF;
					ms_r[g]  <= 11'h000;
				end
				else if (sel[g] != cur_r[g])
				begin
					cur_r[g] <= sel[g];
					ms_r[g]  <= 11'h000;
				end
				else if (tick_ms)
					ms_r[g] <= (ms_r[g] >= pat_last(cur_r[g])) ? 11'h000
						: ms_r[g] + 11'h001;
			end

			assign led_nxt[g] = (sel[g] == cur_r[g]) && pat_level(cur_r[g], ms_r[g]);

			always_ff @(posedge mclk_i or negedge rstn_i)
			begin
				if (!rstn_i)
					led_r[g] <= 1'b0;
				else
					led_r[g] <= led_nxt[g];
			end
		end
	endgenerate

	assign status_led_o = led_r[0];
	assign error_led_o  = led_r[1];

	// ------------------------------------------------------------
	// Link / activity LEDs
	// ------------------------------------------------------------
	logic [1:0] lv_m_r;
	logic [1:0] lv_r;
	logic [1:0] lt_m_r;
	logic [1:0] lt_r;
	logic [5:0] act_ms_r;
	logic       act_ph_r;
	logic [1:0] lnk_r;
	logic [1:0] lnk_nxt;

	// Pin inputs pass two flops before use
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			lv_m_r <= 2'h0;
			lv_r   <= 2'h0;
			lt_m_r <= 2'h0;
			lt_r   <= 2'h0;
		end
		else
		begin
			lv_m_r <= link_valid_i;
			lv_r   <= lv_m_r;
			lt_m_r <= link_traffic_i;
			lt_r   <= lt_m_r;
		end
	end

	// Free-running flicker phase, shared so both ports flicker together
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			act_ms_r <= 6'h00;
			act_ph_r <= 1'b0;
		end
		else if (tick_ms)
		begin
			act_ms_r <= (act_ms_r == 6'(ACT_MS - 1)) ? 6'h00 : act_ms_r + 6'h01;
			if (act_ms_r == 6'(ACT_MS - 1))
				act_ph_r <= ~act_ph_r;
		end
	end

	assign lnk_nxt = lv_r & (~lt_r | {2{act_ph_r}});

	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			lnk_r <= 2'h0;
		else
			lnk_r <= lnk_nxt;
	end

	assign link_activity_in_indicator_o  = lnk_r[0];
	assign link_activity_out_indicator_o = lnk_r[1];

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_OP_ON: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(state_i == FSLED_ST_OP && !fw_download_i)[*2] |=> status_led_o)
		else $error("status LED not lit in operational");
	AST_INIT_OFF: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(state_i == FSLED_ST_INIT && !fw_download_i) |=> !status_led_o)
		else $error("status LED lit in init");
	AST_PREOP_SEL: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(state_i == FSLED_ST_PREOP && !fw_download_i) |-> grn_sel == PAT_BLINK)
		else $error("preop pattern wrong");
	AST_SAFEOP_SEL: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(state_i == FSLED_ST_SAFEOP && !fw_download_i) |-> grn_sel == PAT_SINGLE)
		else $error("safeop pattern wrong");
	AST_DL_FLICK: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		fw_download_i |-> grn_sel == PAT_FLICK)
		else $error("download pattern wrong");
	AST_PDI_ON: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		err_i.pdi_wdog[*2] |=> error_led_o)
		else $error("error LED not steady on watchdog");
	AST_CFG_SEL: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(err_i.cfg_err && !err_i.pdi_wdog) |-> red_sel == PAT_BLINK)
		else $error("config error pattern wrong");
	AST_BOOT_SEL: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(chg_err && state_i == FSLED_ST_INIT && !err_i.pdi_wdog && !err_i.cfg_err)
		|-> red_sel == PAT_FLICK)
		else $error("boot error pattern wrong");
	AST_CHG_SEL: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(chg_err && state_i != FSLED_ST_INIT && !err_i.pdi_wdog && !err_i.cfg_err)
		|-> red_sel == PAT_SINGLE)
		else $error("autonomous change pattern wrong");
	AST_APP_SEL: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(red_sel == PAT_DOUBLE) |-> err_i.app_wdog && !chg_err)
		else $error("double flash without app watchdog");
	AST_APP_DBL: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(err_i.app_wdog && !err_i.pdi_wdog && !err_i.cfg_err && !chg_err)
		|-> red_sel == PAT_DOUBLE)
		else $error("app watchdog pattern wrong");
	AST_NO_ERR: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(!err_i.pdi_wdog && !err_i.cfg_err && !chg_err && !err_i.app_wdog) |=> !error_led_o)
		else $error("error LED lit with no error");
	AST_RESTART: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(sel[0] != cur_r[0]) |=> ms_r[0] == 11'h000)
		else $error("pattern did not restart");
	AST_LINK_OFF: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!lv_r[0] |=> !link_activity_in_indicator_o)
		else $error("link LED lit on invalid link");

	COV_OP:     cover property (@(posedge mclk_i) status_led_o && state_i == FSLED_ST_OP);
	COV_DOUBLE: cover property (@(posedge mclk_i) cur_r[1] == PAT_DOUBLE && ms_r[1] == 11'(2 * BLINK_MS));
	COV_SINGLE: cover property (@(posedge mclk_i) cur_r[0] == PAT_SINGLE && ms_r[0] == 11'(BLINK_MS));
	COV_ACT:    cover property (@(posedge mclk_i) lt_r[1] && lv_r[1] && !lnk_r[1]);

endmodule

// *** bench/fsled_led_model.sv ***
/*
 Model of one status or error LED: counts how long its level has held.
 Assumes the LED pin is driven from logic on the system clock.
*/
`timescale 1ns/1ps

// ------------------------------------------------------------
// LED run-length model
// ------------------------------------------------------------
module fsled_led_model
(
	input  wire logic        mclk_i,
	input  wire logic        rstn_i,
	input  wire logic        led_i,
	output logic [31:0]      run_o
);
	logic last_r;

	// A glitch restarts the count, so a short run exposes a broken steady phase
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			last_r <= 1'b0;
			run_o  <= 32'h0;
		end
		else
		begin
			last_r <= led_i;
			run_o  <= (led_i != last_r) ? 32'h0 : run_o + 32'h1;
		end
	end
endmodule

// *** bench/fsled_indicator_tb.sv ***
/*
 Self-checking bench for the state and error LED generator.
 Assumes the 1 ms tick of the package; runs stay far below one 50 ms phase,
 so every lit pattern is checked in its opening lit phase only.
*/
`timescale 1ns/1ps

module fsled_indicator_tb import fsled_pkg::*;;
	localparam int HOLD = 2000;
	logic         mclk;
	logic         rstn;
	fsled_state_t state;
	logic         fw;
	fsled_err_t   err;
	logic [1:0]   lv;
	logic [1:0]   lt;
	logic         s_led;
	logic         e_led;
	logic         li_led;
	logic         lo_led;
	logic [31:0]  s_run;
	logic [31:0]  e_run;
	int           n_fail;
	int           num_checks;
	int           cyc;

	// ------------------------------------------------------------
	// Design, LED models and clock
	// ------------------------------------------------------------
	fsled_indicator i_dut (.mclk_i(mclk), .rstn_i(rstn), .state_i(state),
		.fw_download_i(fw), .err_i(err), .link_valid_i(lv), .link_traffic_i(lt),
		.status_led_o(s_led), .error_led_o(e_led),
		.link_activity_in_indicator_o(li_led), .link_activity_out_indicator_o(lo_led));
	fsled_led_model i_s (.mclk_i(mclk), .rstn_i(rstn), .led_i(s_led), .run_o(s_run));
	fsled_led_model i_e (.mclk_i(mclk), .rstn_i(rstn), .led_i(e_led), .run_o(e_run));

	always #20 mclk = ~mclk;

	// Hang guard: the whole sequence needs about 70k cycles
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 100000)
		begin
			n_fail++;
			close_out();
		end
	end

	// ------------------------------------------------------------
	// Expectations and checking
	// ------------------------------------------------------------
	// Every pattern except init-dark opens lit after a restart
	function automatic logic exp_status(fsled_state_t s, logic f);
		return !(s == FSLED_ST_INIT && !f);
	endfunction

	// Any error source opens its red pattern lit; other flag values are ignored
	function automatic logic exp_error(fsled_err_t e);
		return e.pdi_wdog | e.cfg_err | e.app_wdog | (e.change == 8'h01);
	endfunction

	task automatic check(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp)
		begin
			$display("BAD %s exp %b got %b", what, exp, got);
			n_fail++;
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Drive one input set, check after the answer latency and after a hold
	task automatic apply(input fsled_state_t s, input logic f, input fsled_err_t e,
		input logic [1:0] v, input logic [1:0] t);
		@(posedge mclk);
		#2;
		state = s;
		fw    = f;
		err   = e;
		lv    = v;
		lt    = t;
		repeat (3) @(posedge mclk);
		#1;
		check("status", exp_status(s, f), s_led);
		check("error", exp_error(e), e_led);
		// Traffic flicker phase is not known here, but an invalid link is always dark
		if (!t[0] || !v[0]) check("link_in", v[0], li_led);
		if (!t[1] || !v[1]) check("link_out", v[1], lo_led);
		repeat (HOLD) @(posedge mclk);
		#1;
		check("status_held", 1'b1, s_run >= HOLD);
		check("error_held", 1'b1, e_run >= HOLD);
		check("status_still", exp_status(s, f), s_led);
	endtask

	// ------------------------------------------------------------
	// Main sequence: corners, mid-run reset, then random sets
	// ------------------------------------------------------------
	initial
	begin
		mclk  = 1'b0;
		rstn  = 1'b0;
		state = FSLED_ST_BOOT;
		fw    = 1'b0;
		err   = '0;
		lv    = 2'h0;
		lt    = 2'h0;
		void'($urandom(9768));
		repeat (2) @(posedge mclk);
		#2;
		rstn = 1'b1;
		apply(FSLED_ST_INIT, 1'b0, '0, 2'h1, 2'h0);
		apply(FSLED_ST_INIT, 1'b0, '{1'b0, 1'b0, 1'b0, 8'h02}, 2'h2, 2'h0);
		apply(FSLED_ST_OP, 1'b0, '{1'b1, 1'b1, 1'b1, 8'h01}, 2'h3, 2'h0);
		// Undefined state code must flicker; traffic on a dead port stays dark
		apply(fsled_state_t'(3'h7), 1'b0, '{1'b0, 1'b0, 1'b1, 8'h00}, 2'h1, 2'h3);
		apply(FSLED_ST_INIT, 1'b1, '{1'b0, 1'b0, 1'b0, 8'h01}, 2'h0, 2'h0);
		// Status and error LEDs must fall at once when reset is applied mid-pattern
		@(posedge mclk);
		#2;
		rstn = 1'b0;
		#1;
		check("rst_status", 1'b0, s_led);
		check("rst_error", 1'b0, e_led);
		repeat (2) @(posedge mclk);
		#2;
		rstn = 1'b1;
		for (int i = 0; i < 28; i++)
			apply(fsled_state_t'($urandom % 6), 1'($urandom % 4 == 0),
				'{1'($urandom), 1'($urandom), 1'($urandom), 8'($urandom % 3)},
				2'($urandom), 2'($urandom));
		close_out();
	end
endmodule
